// File: rtl/aim_cfg.svh
`ifndef AIM_CFG_SVH
`define AIM_CFG_SVH
// How it works
// - Identify word 53 reads fixed 0001h
// - Capacity equals cylinders times heads times sectors
// - Word 59 high byte reads 01h always
// - Multiple setting is 00h by default, else 01h
// - DMA timing word reports no DMA mode
// - Idle: busy, idle, clear busy, interrupt
// - Nonzero count arms power-down in 5 ms units
// - Zero count disables automatic power-down
// - Idle immediate: same sequence, count ignored
// - Init parameters: sectors from count, heads plus one
// - Read buffer sends buffer like sector read
// - Multiple read block size is one sector
// - Interrupt and data request only per block
// - Count is sectors; partial last block sent
// - Multiple read without setting is aborted
// - Media error posted at block start, still sent
// - Count 1 to 256, zero means 256
// - Address registers end on last sector read
// - On uncorrectable error address stays at failing sector
// - Continue only after correctable data error
// - Per sector: busy, load, request, interrupt
// - Identify advertises one sector per interrupt

// ****************************************************
// Timing
// ****************************************************
`define AIM_CLK_NS      25
`define AIM_PD_UNIT_NS  5000000

// ****************************************************
// Register byte offsets
// ****************************************************
`define AIM_OFF_CMD     8'h00
`define AIM_OFF_SECCNT  8'h04
`define AIM_OFF_SECNUM  8'h08
`define AIM_OFF_CYLLO   8'h0C
`define AIM_OFF_CYLHI   8'h10
`define AIM_OFF_DRVHD   8'h14
`define AIM_OFF_STATUS  8'h18
`define AIM_OFF_ERROR   8'h1C
`define AIM_OFF_DATA    8'h20
`define AIM_OFF_IDSEL   8'h24
`define AIM_OFF_IDDATA  8'h28
`define AIM_OFF_POWER   8'h2C

// ****************************************************
// Opcodes
// ****************************************************
`define AIM_OP_IDLE_A   8'hE3
`define AIM_OP_IDLE_B   8'h97
`define AIM_OP_IMM_A    8'hE1
`define AIM_OP_IMM_B    8'h95
`define AIM_OP_INIT     8'h91
`define AIM_OP_RDBUF    8'hE4
`define AIM_OP_RDMUL    8'hC4
`define AIM_OP_SETMUL   8'hC6

// ****************************************************
// Field positions and fixed values
// ****************************************************
`define AIM_ST_BSY      7
`define AIM_ST_DRDY     6
`define AIM_ST_DSC      4
`define AIM_ST_DRQ      3
`define AIM_ST_CORR     2
`define AIM_ST_ERR      0
`define AIM_ER_UNC      6
`define AIM_ER_ABRT     2
`define AIM_DH_LBA      6
`define AIM_ID_MAXMUL   16'h0001
`define AIM_ID_DMA      16'h0000
`define AIM_ID_XLAT     16'h0001
`define AIM_ID_MULVAL   8'h01
`define AIM_MUL_RST     8'h00
`define AIM_MUL_ONE     8'h01
`define AIM_LAST_WORD   8'hFF
`define AIM_RESP_OK     2'h0
`define AIM_RESP_ERR    2'h2
`endif

// File: rtl/aim_pkg.sv
package aim_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_LOAD, ST_XFER} aim_state_t;
  typedef struct packed {
    logic [3:0]  head;
    logic [15:0] cyl;
    logic [7:0]  sec;
  } aim_addr_t;
  typedef struct packed {
    logic      req;
    logic      lba;
    aim_addr_t addr;
  } aim_media_req_t;
endpackage : aim_pkg

// File: rtl/aim_ata_cmd.sv
`timescale 1ns/100ps
`include "aim_cfg.svh"
module aim_ata_cmd #(
  parameter logic [15:0] DEF_CYL   = 16'h0100,
  parameter logic [4:0]  DEF_HEADS = 5'h04,
  parameter logic [7:0]  DEF_SPT   = 8'h20,
  parameter int          PD_TICK   = `AIM_PD_UNIT_NS / `AIM_CLK_NS
) (
  // Clock, reset and enable
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  // AXI4-Lite slave
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [7:0]              awaddr,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire logic [7:0]              araddr,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  // Media side
  output aim_pkg::aim_media_req_t      media_req_q,
  input  wire logic                    media_ack,
  input  wire logic                    media_err,
  input  wire logic                    media_corr,
  input  wire logic                    mbuf_we,
  input  wire logic [7:0]              mbuf_addr,
  input  wire logic [15:0]             mbuf_data,
  // Host signals
  output logic                         intrq_q,
  output logic                         pwr_down_q
);

  // ****************************************************
  // State
  // ****************************************************
  aim_pkg::aim_state_t st_q;
  logic [15:0]         buf_mem [256];
  logic [7:0]          aw_addr_q, w_data_q, op_q, sc_q, dh_q, ptr_q, id_sel_q;
  logic [7:0]          mult_q, spt_q, units_q;
  logic [4:0]          heads_q;
  logic [8:0]          cnt_q;
  logic [17:0]         tick_q;
  logic                w_strb_q, bsy_q, drq_q, err_q, corr_q, unc_q, abrt_q;
  logic                fatal_q, pd_en_q;
  aim_pkg::aim_addr_t  adr_q;

  function automatic logic mapped(input logic [7:0] a);
    return a <= `AIM_OFF_POWER && a[1:0] == 2'h0;
  endfunction : mapped

  function automatic aim_pkg::aim_addr_t next_addr(input aim_pkg::aim_addr_t a,
                                                  input logic lba,
                                                  input logic [4:0] hd,
                                                  input logic [7:0] spt);
    aim_pkg::aim_addr_t n;
    n = a;
    if (lba) begin
      n = a + 28'h1;
    end else if (a.sec < spt) begin
      n.sec = a.sec + 8'h01;
    end else begin
      n.sec = 8'h01;
      if ({1'b0, a.head} < hd - 5'h01) begin
        n.head = a.head + 4'h1;
      end else begin
        n.head = 4'h0;
        n.cyl  = a.cyl + 16'h0001;
      end
    end
    return n;
  endfunction : next_addr

  // ****************************************************
  // Decode
  // ****************************************************
  wire        wr_go    = ~awready & ~wready & ~bvalid;
  wire        ar_take  = arvalid & arready;
  wire        wr_ok    = wr_go & w_strb_q & ~bsy_q & st_q == aim_pkg::ST_IDLE;
  wire        cmd_go   = wr_ok & aw_addr_q == `AIM_OFF_CMD;
  wire        sts_rd   = ar_take & araddr == `AIM_OFF_STATUS;
  wire        data_rd  = ar_take & araddr == `AIM_OFF_DATA & st_q == aim_pkg::ST_XFER;
  wire        op_idle  = op_q == `AIM_OP_IDLE_A || op_q == `AIM_OP_IDLE_B;
  wire        op_imm   = op_q == `AIM_OP_IMM_A || op_q == `AIM_OP_IMM_B;
  wire        last_wd  = ptr_q == `AIM_LAST_WORD;
  wire [31:0] cap      = {16'h0, DEF_CYL} * {27'h0, heads_q} * {24'h0, spt_q};
  wire [7:0]  status   = {bsy_q, ~bsy_q, 1'b0, 1'b1, drq_q, corr_q, 1'b0, err_q};
  wire [7:0]  err_reg  = {1'b0, unc_q, 3'h0, abrt_q, 2'h0};
  wire [7:0]  sec_cnt  = sc_q;
  logic [15:0] id_word;
  logic [31:0] rd_mux;

  always_comb begin
    unique case (id_sel_q)
      8'd47:   id_word = `AIM_ID_MAXMUL;
      8'd52:   id_word = `AIM_ID_DMA;
      8'd53:   id_word = `AIM_ID_XLAT;
      8'd54:   id_word = DEF_CYL;
      8'd55:   id_word = {11'h0, heads_q};
      8'd56:   id_word = {8'h0, spt_q};
      8'd57:   id_word = cap[15:0];
      8'd58:   id_word = cap[31:16];
      8'd59:   id_word = {`AIM_ID_MULVAL, mult_q};
      default: id_word = 16'h0000;
    endcase
  end

  always_comb begin
    unique case (araddr)
      `AIM_OFF_CMD,
      `AIM_OFF_STATUS: rd_mux = {24'h0, status};
      `AIM_OFF_SECCNT: rd_mux = {24'h0, sec_cnt};
      `AIM_OFF_SECNUM: rd_mux = {24'h0, adr_q.sec};
      `AIM_OFF_CYLLO:  rd_mux = {24'h0, adr_q.cyl[7:0]};
      `AIM_OFF_CYLHI:  rd_mux = {24'h0, adr_q.cyl[15:8]};
      `AIM_OFF_DRVHD:  rd_mux = {24'h0, dh_q[7:4], adr_q.head};
      `AIM_OFF_ERROR:  rd_mux = {24'h0, err_reg};
      `AIM_OFF_DATA:   rd_mux = st_q == aim_pkg::ST_XFER ? {16'h0, buf_mem[ptr_q]} : 32'h0;
      `AIM_OFF_IDSEL:  rd_mux = {24'h0, id_sel_q};
      `AIM_OFF_IDDATA: rd_mux = {16'h0, id_word};
      `AIM_OFF_POWER:  rd_mux = {23'h0, pd_en_q, units_q};
      default:         rd_mux = 32'h0;
    endcase
  end

  // ****************************************************
  // AXI4-Lite handshake
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready, wready, arready} <= 3'b111;
      {bvalid, rvalid}           <= 2'b00;
      {bresp, rresp}             <= 4'h0;
      rdata                      <= 32'h0;
      {aw_addr_q, w_data_q}      <= 16'h0;
      w_strb_q                   <= 1'b0;
    end else if (ce) begin
      if (awvalid & awready) begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid & wready) begin
        wready   <= 1'b0;
        w_data_q <= wdata[7:0];
        w_strb_q <= wstrb[0];
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= mapped(aw_addr_q) ? `AIM_RESP_OK : `AIM_RESP_ERR;
      end
      if (bvalid & bready) begin
        {bvalid, awready, wready} <= 3'b011;
      end
      if (ar_take) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_mux;
        rresp   <= mapped(araddr) ? `AIM_RESP_OK : `AIM_RESP_ERR;
      end
      if (rvalid & rready) begin
        {rvalid, arready} <= 2'b01;
      end
    end
  end

  // ****************************************************
  // Sector buffer
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (ce && mbuf_we) begin
      buf_mem[mbuf_addr] <= mbuf_data;
    end
  end

  // ****************************************************
  // Power-down timer
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q     <= 18'h0;
      units_q    <= 8'h0;
      pd_en_q    <= 1'b0;
      pwr_down_q <= 1'b0;
    end else if (ce) begin
      if (cmd_go) begin
        pd_en_q    <= 1'b0;
        pwr_down_q <= 1'b0;
      end else if (st_q == aim_pkg::ST_CMD && op_idle) begin
        pd_en_q <= sc_q != 8'h00;
        units_q <= sc_q;
        tick_q  <= 18'h0;
      end else if (pd_en_q) begin
        tick_q <= tick_q + 18'h1;
        if (tick_q == 18'(PD_TICK - 1)) begin
          tick_q  <= 18'h0;
          units_q <= units_q - 8'h01;
          if (units_q == 8'h01) begin
            pd_en_q    <= 1'b0;
            pwr_down_q <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************************
  // Command engine
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= aim_pkg::ST_IDLE;
      {op_q, sc_q, dh_q, ptr_q, id_sel_q} <= 40'h0;
      adr_q       <= '0;
      mult_q      <= `AIM_MUL_RST;
      spt_q       <= DEF_SPT;
      heads_q     <= DEF_HEADS;
      cnt_q       <= 9'h0;
      {bsy_q, drq_q, err_q, corr_q, unc_q, abrt_q, fatal_q} <= 7'h0;
      intrq_q     <= 1'b0;
      media_req_q <= '0;
    end else if (ce) begin
      if (sts_rd) begin
        intrq_q <= 1'b0;
      end
      if (wr_ok) begin
        unique case (aw_addr_q)
          `AIM_OFF_SECCNT: sc_q <= w_data_q;
          `AIM_OFF_SECNUM: adr_q.sec <= w_data_q;
          `AIM_OFF_CYLLO:  adr_q.cyl[7:0] <= w_data_q;
          `AIM_OFF_CYLHI:  adr_q.cyl[15:8] <= w_data_q;
          `AIM_OFF_DRVHD: begin
            dh_q       <= w_data_q;
            adr_q.head <= w_data_q[3:0];
          end
          `AIM_OFF_IDSEL:  id_sel_q <= w_data_q;
          default: ;
        endcase
      end
      unique case (st_q)
        aim_pkg::ST_IDLE: if (cmd_go) begin
          bsy_q <= 1'b1;
          op_q  <= w_data_q;
          {err_q, corr_q, unc_q, abrt_q, fatal_q} <= 5'h0;
          st_q  <= aim_pkg::ST_CMD;
        end
        aim_pkg::ST_CMD: begin
          bsy_q   <= 1'b0;
          intrq_q <= 1'b1;
          st_q    <= aim_pkg::ST_IDLE;
          if (op_idle || op_imm) begin
          end else if (op_q == `AIM_OP_INIT) begin
            spt_q   <= sc_q;
            heads_q <= {1'b0, dh_q[3:0]} + 5'h01;
          end else if (op_q == `AIM_OP_SETMUL) begin
            mult_q <= sc_q == `AIM_MUL_ONE ? `AIM_MUL_ONE : `AIM_MUL_RST;
          end else if (op_q == `AIM_OP_RDBUF) begin
            drq_q <= 1'b1;
            ptr_q <= 8'h0;
            cnt_q <= 9'h0;
            st_q  <= aim_pkg::ST_XFER;
          end else if (op_q == `AIM_OP_RDMUL && mult_q != `AIM_MUL_RST) begin
            bsy_q       <= 1'b1;
            intrq_q     <= 1'b0;
            cnt_q       <= {1'b0, sc_q - 8'h01};
            media_req_q <= '{req: 1'b1, lba: dh_q[`AIM_DH_LBA], addr: adr_q};
            st_q        <= aim_pkg::ST_LOAD;
          end else begin
            abrt_q <= 1'b1;
            err_q  <= 1'b1;
          end
        end
        aim_pkg::ST_LOAD: if (media_ack) begin
          media_req_q.req <= 1'b0;
          bsy_q   <= 1'b0;
          drq_q   <= 1'b1;
          intrq_q <= 1'b1;
          ptr_q   <= 8'h0;
          st_q    <= aim_pkg::ST_XFER;
          if (media_err) begin
            err_q   <= 1'b1;
            corr_q  <= media_corr;
            unc_q   <= ~media_corr;
            fatal_q <= ~media_corr;
          end
        end
        aim_pkg::ST_XFER: if (data_rd) begin
          ptr_q <= ptr_q + 8'h01;
          if (last_wd) begin
            drq_q <= 1'b0;
            if (cnt_q == 9'h0 || fatal_q) begin
              st_q <= aim_pkg::ST_IDLE;
            end else begin
              bsy_q       <= 1'b1;
              cnt_q       <= cnt_q - 9'h001;
              adr_q       <= next_addr(adr_q, dh_q[`AIM_DH_LBA], heads_q, spt_q);
              media_req_q <= '{req: 1'b1, lba: dh_q[`AIM_DH_LBA],
                               addr: next_addr(adr_q, dh_q[`AIM_DH_LBA], heads_q, spt_q)};
              st_q        <= aim_pkg::ST_LOAD;
            end
          end
        end
        default: st_q <= aim_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  wire idle_cmd = cmd_go && (w_data_q == `AIM_OP_IDLE_A || w_data_q == `AIM_OP_IDLE_B);
  wire imm_cmd  = cmd_go && (w_data_q == `AIM_OP_IMM_A || w_data_q == `AIM_OP_IMM_B);

  idle_sequence_a: assert property (idle_cmd |=> bsy_q ##1 !bsy_q && intrq_q)
    else $error("idle command did not pulse busy then interrupt");
  imm_idle_a: assert property (imm_cmd |=> bsy_q ##1 !bsy_q && intrq_q && !pd_en_q)
    else $error("idle immediate sequence wrong");
  pd_arm_a: assert property (idle_cmd && sc_q != 8'h00 |=> ##1 pd_en_q && units_q == $past(sc_q, 2))
    else $error("nonzero idle count did not arm timer");
  pd_disarm_a: assert property (idle_cmd && sc_q == 8'h00 |=> ##1 !pd_en_q)
    else $error("zero idle count left timer armed");
  pd_cancel_a: assert property (cmd_go |=> !pd_en_q && !pwr_down_q)
    else $error("new command did not cancel power-down");
  mult_abort_a: assert property (cmd_go && w_data_q == `AIM_OP_RDMUL && mult_q == `AIM_MUL_RST
                                 |=> ##1 abrt_q && err_q && intrq_q && !bsy_q)
    else $error("multiple read without setting not aborted");
  init_geom_a: assert property (cmd_go && w_data_q == `AIM_OP_INIT
                                |=> ##1 spt_q == $past(sc_q, 2) &&
                                heads_q == {1'b0, $past(dh_q[3:0], 2)} + 5'h01)
    else $error("geometry not taken from count and head field");
  drq_irq_a: assert property ($rose(drq_q) |-> intrq_q && !bsy_q)
    else $error("data request without interrupt");
  mult_word_a: assert property (mult_q == `AIM_MUL_RST || mult_q == `AIM_MUL_ONE)
    else $error("illegal multiple setting");
  err_xfer_a: assert property (st_q == aim_pkg::ST_LOAD && media_ack && media_err
                               |=> drq_q && err_q)
    else $error("media error blocked the transfer");
  rd_count_a: assert property (cmd_go && w_data_q == `AIM_OP_RDMUL
                               && mult_q == `AIM_MUL_ONE
                               |=> ##1 cnt_q == ($past(sc_q, 2) == 8'h00 ? 9'h0FF
                                                 : {1'b0, $past(sc_q, 2)} - 9'h001))
    else $error("read count not loaded as sectors left");

  idle_cov: cover property (idle_cmd ##[1:4] intrq_q);
  rdmul_cov: cover property ($rose(drq_q) && st_q == aim_pkg::ST_XFER && cnt_q != 9'h0);
  pd_cov: cover property ($rose(pwr_down_q));

endmodule : aim_ata_cmd

// File: verification/aim_media_model.sv
`timescale 1ns/100ps
// ****************************************************
// Media side model
// ****************************************************
module aim_media_model (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Request side
  input  wire aim_pkg::aim_media_req_t media_req,
  input  wire logic                    err_en,
  input  wire logic                    err_corr,
  input  wire logic [31:0]             delay,
  // Answer side
  output logic                         media_ack,
  output logic                         media_err,
  output logic                         media_corr,
  output logic                         mbuf_we,
  output logic [7:0]                   mbuf_addr,
  output logic [15:0]                  mbuf_data
);
  // Each sector word carries the sector number and its own index.
  // Between loads the buffer lines show the inverse of their last value.
  initial begin
    media_ack = 1'b0;
    media_err = 1'b0;
    media_corr = 1'b0;
    mbuf_we = 1'b0;
    mbuf_addr = 8'h00;
    mbuf_data = 16'h0000;
    forever begin
      @(posedge aclk);
      if (aresetn && media_req.req) begin
        repeat (delay) @(posedge aclk);
        for (int i = 0; i < 256; i++) begin
          mbuf_we <= 1'b1;
          mbuf_addr <= i[7:0];
          mbuf_data <= {media_req.addr.sec, i[7:0]};
          @(posedge aclk);
        end
        mbuf_we <= 1'b0;
        mbuf_addr <= ~mbuf_addr;
        mbuf_data <= ~mbuf_data;
        media_ack <= 1'b1;
        media_err <= err_en;
        media_corr <= err_en & err_corr;
        @(posedge aclk);
        media_ack <= 1'b0;
        media_err <= ~media_err;
        media_corr <= ~media_corr;
        @(posedge aclk);
      end
    end
  end
endmodule : aim_media_model

// File: verification/testbench.sv
`timescale 1ns/100ps
`include "aim_cfg.svh"
module testbench;
  localparam int PD_TICK = 10;
  logic                    aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                    arvalid, arready, rvalid, rready, intrq_q, pwr_down_q;
  logic                    media_ack, media_err, media_corr, mbuf_we, err_en, err_corr;
  logic [7:0]              awaddr, araddr, mbuf_addr;
  logic [15:0]             mbuf_data;
  logic [31:0]             wdata, rdata, v;
  logic [3:0]              wstrb;
  logic [1:0]              bresp, rresp;
  aim_pkg::aim_media_req_t media_req_q;
  int                      fails, n_checks, seed, delay, cyl, heads, spt, mul, c, h, s;

  aim_ata_cmd #(.PD_TICK(PD_TICK)) DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .media_req_q(media_req_q), .media_ack(media_ack),
    .media_err(media_err), .media_corr(media_corr), .mbuf_we(mbuf_we), .mbuf_addr(mbuf_addr),
    .mbuf_data(mbuf_data), .intrq_q(intrq_q), .pwr_down_q(pwr_down_q));
  aim_media_model media (.aclk(aclk), .aresetn(aresetn), .media_req(media_req_q),
    .err_en(err_en), .err_corr(err_corr), .delay(delay), .media_ack(media_ack),
    .media_err(media_err), .media_corr(media_corr), .mbuf_we(mbuf_we),
    .mbuf_addr(mbuf_addr), .mbuf_data(mbuf_data));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] val);
    int          k;
    logic [31:0] r;
    k = 0;
    r = $random(seed);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {r[31:8], val};
    wstrb <= 4'hF;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 200);
    bready <= 1'b0;
    chk({bvalid, bresp}, 32'h4, "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] val);
    int k;
    k = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 200);
    val = rdata;
    rready <= 1'b0;
    chk({rvalid, rresp}, 32'h4, "read response");
  endtask : rd

  task automatic cmd(input logic [7:0] op, input logic [7:0] cnt);
    wr(`AIM_OFF_SECCNT, cnt);
    wr(`AIM_OFF_CMD, op);
  endtask : cmd

  // Waits for the interrupt, then reads STATUS, which also clears it.
  task automatic wait_irq(output logic [31:0] st);
    int k;
    k = 0;
    while (intrq_q !== 1'b1 && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    chk(intrq_q, 1, "interrupt missing");
    rd(`AIM_OFF_STATUS, st);
  endtask : wait_irq

  task automatic id_check();
    int          ws[9];
    logic [31:0] cap, e;
    ws = '{47, 52, 53, 54, 55, 56, 57, 58, 59};
    cap = cyl * heads * spt;
    foreach (ws[i]) begin
      e = ws[i] == 47 ? 1 : ws[i] == 52 ? 0 : ws[i] == 53 ? 1 : ws[i] == 54 ? cyl :
          ws[i] == 55 ? heads : ws[i] == 56 ? spt : ws[i] == 57 ? cap[15:0] :
          ws[i] == 58 ? cap[31:16] : 32'h0100 + mul;
      wr(`AIM_OFF_IDSEL, ws[i][7:0]);
      rd(`AIM_OFF_IDDATA, v);
      chk(v, e, "identify word");
    end
  endtask : id_check

  task automatic set_addr(input int cc, input int hh, input int ss);
    c = cc;
    h = hh;
    s = ss;
    delay = 2 + ($random(seed) & 15);
    wr(`AIM_OFF_SECNUM, s[7:0]);
    wr(`AIM_OFF_CYLLO, c[7:0]);
    wr(`AIM_OFF_CYLHI, c[15:8]);
    wr(`AIM_OFF_DRVHD, {4'hA, h[3:0]});
  endtask : set_addr

  task automatic chk_addr();
    rd(`AIM_OFF_SECNUM, v);
    chk(v & 32'hFF, s, "sector number");
    rd(`AIM_OFF_CYLLO, v);
    chk(v & 32'hFF, c & 8'hFF, "cylinder low");
    rd(`AIM_OFF_CYLHI, v);
    chk(v & 32'hFF, c >> 8, "cylinder high");
    rd(`AIM_OFF_DRVHD, v);
    chk(v & 32'h0F, h, "head");
  endtask : chk_addr

  // One block: status at its start, then 256 data words.
  task automatic rd_sector(input int sec, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] st;
    wait_irq(st);
    err_en <= 1'b0;
    chk(st & mask, exp, "block start status");
    for (int i = 0; i < 256; i++) begin
      rd(`AIM_OFF_DATA, st);
      chk(st, {16'h0, sec[7:0], i[7:0]}, "data word");
    end
  endtask : rd_sector

  task automatic adv();
    s++;
    if (s > spt) begin
      s = 1;
      h++;
      if (h == heads) begin
        h = 0;
        c++;
      end
    end
  endtask : adv

  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    seed = 32'hC13B;
    {awvalid, wvalid, bready, arvalid, rready, err_en, err_corr} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    aresetn = 1'b0;
    ce = 1'b1;
    delay = 3;
    cyl = 256;
    heads = 4;
    spt = 32;
    mul = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    id_check();
    $display("test identify done");
    cmd(`AIM_OP_RDMUL, 8'h01);
    wait_irq(v);
    chk(v & 32'h81, 32'h01, "abort status");
    rd(`AIM_OFF_ERROR, v);
    chk(v & 32'h04, 32'h04, "abort error");
    $display("test refused multiple read done");
    cmd(`AIM_OP_IDLE_A, 8'h08);
    wait_irq(v);
    chk(v & 32'h81, 32'h00, "idle status");
    rd(`AIM_OFF_POWER, v);
    chk(v & 32'h100, 32'h100, "timer armed");
    repeat (8 * PD_TICK - 30) @(posedge aclk);
    chk(pwr_down_q, 0, "early power down");
    repeat (40) @(posedge aclk);
    chk(pwr_down_q, 1, "power down missing");
    cmd(`AIM_OP_IMM_B, 8'h03);
    wait_irq(v);
    chk({v[7], v[0], pwr_down_q}, 0, "immediate idle");
    cmd(`AIM_OP_IDLE_B, 8'h00);
    wait_irq(v);
    rd(`AIM_OFF_POWER, v);
    chk(v & 32'h100, 0, "timer disabled");
    repeat (60) @(posedge aclk);
    chk(pwr_down_q, 0, "power down while disabled");
    cmd(`AIM_OP_IMM_A, 8'h00);
    wait_irq(v);
    chk(v & 32'h81, 0, "immediate idle status");
    $display("test idle done");
    wr(`AIM_OFF_CYLLO, 8'h55);
    wr(`AIM_OFF_DRVHD, 8'hA5);
    cmd(`AIM_OP_INIT, 8'h11);
    wait_irq(v);
    heads = 6;
    spt = 17;
    id_check();
    cmd(`AIM_OP_SETMUL, 8'h01);
    wait_irq(v);
    mul = 1;
    id_check();
    $display("test geometry done");
    set_addr(16, 5, 17);
    cmd(`AIM_OP_RDMUL, 8'h02);
    rd_sector(s, 32'h89, 32'h08);
    adv();
    rd_sector(s, 32'h89, 32'h08);
    repeat (10) @(posedge aclk);
    chk(intrq_q, 0, "extra interrupt");
    rd(`AIM_OFF_STATUS, v);
    chk(v & 32'h89, 0, "end status");
    chk_addr();
    $display("test multiple read done");
    set_addr(32, 1, 3);
    err_en <= 1'b1;
    err_corr <= 1'b1;
    cmd(`AIM_OP_RDMUL, 8'h02);
    rd_sector(s, 32'h8D, 32'h0D);
    adv();
    rd_sector(s, 32'h88, 32'h08);
    set_addr(32, 1, 9);
    err_en <= 1'b1;
    err_corr <= 1'b0;
    cmd(`AIM_OP_RDMUL, 8'h03);
    rd_sector(s, 32'h89, 32'h09);
    repeat (20) @(posedge aclk);
    rd(`AIM_OFF_STATUS, v);
    chk({v[7], v[3], v[0], intrq_q, media_req_q.req}, 5'b00100, "stop after error");
    rd(`AIM_OFF_ERROR, v);
    chk(v & 32'h40, 32'h40, "uncorrectable bit");
    chk_addr();
    $display("test media errors done");
    cmd(`AIM_OP_RDBUF, 8'h00);
    rd_sector(9, 32'h89, 32'h08);
    $display("test read buffer done");
    tally_and_finish();
  end
endmodule : testbench
